// >>> src/alert_fault_mask_status_regs.sv
// alert/fault mask registers, general and phase status, thermal conversion constants
// assumes the bus engine issues one-cycle wr/rd strobes on clk_i and all inputs are synchronous
`default_nettype none
module alert_fault_mask_status_regs
	import mon_regs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire mon_regs_pkg::reg_req_s req_i,
	input wire mon_regs_pkg::src_flags_s alert_src_i,
	input wire mon_regs_pkg::src_flags_s fault_src_i,
	input wire logic power_good_i,
	input wire logic ready_i,
	input wire logic [5:0] phase_en_i,
	input wire logic [15:0] thermal_sense_input_i,
	output logic [15:0] rdata_o,
	output logic rvalid_o,
	output logic alert_o,
	output logic fault_o,
	output logic [15:0] temperature_o,
	output logic [15:0] monitor_warn_limit_o,
	output logic [7:0] alert_src_o,
	output logic [7:0] fault_src_o
);

	logic [15:0] monitor_warn_limit_q;
	logic [15:0] thermal_sense_gain_q;
	logic [15:0] thermal_sense_offset_q;
	logic [7:0] alert_mask_q;
	logic [7:0] fault_mask_q;
	logic [7:0] general_status_q;
	logic [7:0] phase_enable_status_q;
	logic alert_d;
	logic fault_d;
	logic [31:0] product_t;
	logic [15:0] temperature_d;

	////////////////////////////////////////////////////////////////////////////
	// host writes

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			monitor_warn_limit_q <= RST_MON_WARN;
			thermal_sense_gain_q <= RST_TS_GAIN;
			thermal_sense_offset_q <= RST_TS_OFFSET;
			alert_mask_q <= RST_MASK;
			fault_mask_q <= RST_MASK;
		end else if (req_i.wr) begin
			case (req_i.addr)
				OFS_MON_WARN: monitor_warn_limit_q <= req_i.wdata;
				OFS_TS_GAIN: thermal_sense_gain_q <= req_i.wdata;
				OFS_TS_OFFSET: thermal_sense_offset_q <= req_i.wdata;
				OFS_ALERT_MASK: alert_mask_q <= req_i.wdata[7:0];
				OFS_FAULT_MASK: fault_mask_q <= req_i.wdata[7:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// indication aggregation

	// a set mask bit removes its source; the source flags themselves pass untouched
	assign alert_d = |(alert_src_i & ~alert_mask_q);
	assign fault_d = |(fault_src_i & ~fault_mask_q);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			alert_o <= 1'b0;
			fault_o <= 1'b0;
			alert_src_o <= RST_MASK;
			fault_src_o <= RST_MASK;
		end else begin
			alert_o <= alert_d;
			fault_o <= fault_d;
			alert_src_o <= alert_src_i;
			fault_src_o <= fault_src_i;
		end
	end

	// general status is live: host writes are ignored since bits 7:4 mirror hardware and bits 3:0 read zero
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			general_status_q <= RST_STATUS;
		end else begin
			general_status_q <= RST_STATUS;
			general_status_q[GS_FAULT] <= fault_d;
			general_status_q[GS_ALERT] <= alert_d;
			general_status_q[GS_PGOOD] <= power_good_i;
			general_status_q[GS_READY] <= ready_i;
		end
	end

	// phase 1 is always on and has no bit
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_enable_status_q <= RST_STATUS;
		end else begin
			phase_enable_status_q <= {phase_en_i[5:1], 3'h0};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// temperature conversion

	// gain is taken as 8.8 fixed point; saturation is left to the consumer
	assign product_t = thermal_sense_input_i * thermal_sense_gain_q;
	assign temperature_d = 16'(product_t[31:GAIN_FRAC]) - thermal_sense_offset_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			temperature_o <= 16'h0000;
			monitor_warn_limit_o <= RST_MON_WARN;
		end else begin
			temperature_o <= temperature_d;
			monitor_warn_limit_o <= monitor_warn_limit_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// host reads

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 16'h0000;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= req_i.rd;
			if (req_i.rd) begin
				case (req_i.addr)
					OFS_MON_WARN: rdata_o <= monitor_warn_limit_q;
					OFS_TS_GAIN: rdata_o <= thermal_sense_gain_q;
					OFS_TS_OFFSET: rdata_o <= thermal_sense_offset_q;
					OFS_ALERT_MASK: rdata_o <= {8'h00, alert_mask_q};
					OFS_FAULT_MASK: rdata_o <= {8'h00, fault_mask_q};
					OFS_GEN_STATUS: rdata_o <= {8'h00, general_status_q};
					OFS_PHASE_STATUS: rdata_o <= {8'h00, phase_enable_status_q};
					default: rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	// masks are checked one source at a time (alert vout: other alert sources only masked or idle) so that a leak from another source cannot hide a failure
	a_alert_masked_vout: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		alert_mask_q[7] && !(|(alert_src_i[6:0] & ~alert_mask_q[6:0])) |=> !alert_o)
		else $error("alert raised by masked vout group");
	a_alert_masked_mon: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		alert_src_i == 8'h04 && alert_mask_q[2] |=> !alert_o)
		else $error("alert raised by masked monitor input");
	a_alert_masked_sense: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		alert_src_i == 8'h02 && alert_mask_q[1] |=> !alert_o)
		else $error("alert raised by masked second sense");
	a_alert_masked_power: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		alert_src_i == 8'h01 && alert_mask_q[0] |=> !alert_o)
		else $error("alert raised by masked output power");
	a_fault_masked_group: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		fault_src_i == 8'h80 && fault_mask_q[7] |=> !fault_o)
		else $error("fault raised by masked vout group");
	a_fault_masked_mon: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		fault_src_i == 8'h04 && fault_mask_q[2] |=> !fault_o)
		else $error("fault raised by masked monitor input");
	a_fault_masked_sense: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		fault_src_i == 8'h02 && fault_mask_q[1] |=> !fault_o)
		else $error("fault raised by masked second sense");
	a_fault_masked_power: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		fault_src_i == 8'h01 && fault_mask_q[0] |=> !fault_o)
		else $error("fault raised by masked output power");
	a_status_tracks_ind: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		##1 general_status_q[GS_FAULT] == $past(|(fault_src_i & ~fault_mask_q))
		&& general_status_q[GS_ALERT] == $past(|(alert_src_i & ~alert_mask_q)))
		else $error("general status disagrees with unmasked sources");
	a_status_aux_bits: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		##1 general_status_q[GS_PGOOD] == $past(power_good_i) && general_status_q[GS_READY] == $past(ready_i)
		&& general_status_q[GS_READY-1:0] == 4'h0)
		else $error("power-good or ready status wrong");
	a_phase_hi_bits: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		##1 phase_enable_status_q[7:6] == $past(phase_en_i[5:4]))
		else $error("phase 6/5 status wrong");
	a_phase_lo_bits: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		##1 phase_enable_status_q[5:3] == $past(phase_en_i[3:1]))
		else $error("phase 4..2 status wrong");
	a_unmasked_raises: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(alert_src_i & ~alert_mask_q) != 8'h00 |=> alert_o)
		else $error("unmasked alert source not indicated");
	a_flags_kept: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		fault_mask_q[3] && fault_src_i[3] |=> fault_src_o[3])
		else $error("masked source flag lost");
	a_gain_written: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		req_i.wr && req_i.addr == OFS_TS_GAIN |=> thermal_sense_gain_q == $past(req_i.wdata))
		else $error("gain write not stored");
	a_offset_written: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		req_i.wr && req_i.addr == OFS_TS_OFFSET |=> thermal_sense_offset_q == $past(req_i.wdata))
		else $error("offset write not stored");
	a_alert_masked_comm: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		alert_src_i == 8'h08 && alert_mask_q[3] |=> !alert_o)
		else $error("alert raised by masked comm logic group");
	a_fault_masked_temp: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		fault_src_i == 8'h10 && fault_mask_q[4] |=> !fault_o)
		else $error("fault raised by masked temperature group");
	a_fault_unmasked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(fault_src_i & ~fault_mask_q) != 8'h00 |=> fault_o)
		else $error("unmasked fault source not indicated");
	a_alert_flag_kept: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		alert_mask_q[2] && alert_src_i[2] |=> alert_src_o[2])
		else $error("masked alert source flag lost");

endmodule
`default_nettype wire

// >>> src/mon_regs_pkg.sv
// package for the alert/fault mask and status register bank
// assumes a single 250 MHz clock domain shared with the management bus engine
`default_nettype none
package mon_regs_pkg;
	localparam logic [7:0] OFS_MON_WARN = 8'hF6;
	localparam logic [7:0] OFS_TS_GAIN = 8'hF7;
	localparam logic [7:0] OFS_TS_OFFSET = 8'hF8;
	localparam logic [7:0] OFS_ALERT_MASK = 8'hF9;
	localparam logic [7:0] OFS_FAULT_MASK = 8'hFA;
	localparam logic [7:0] OFS_GEN_STATUS = 8'hFB;
	localparam logic [7:0] OFS_PHASE_STATUS = 8'hFC;
	localparam logic [15:0] RST_MON_WARN = 16'h0002;
	localparam logic [15:0] RST_TS_GAIN = 16'h07CE;
	localparam logic [15:0] RST_TS_OFFSET = 16'h007B;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;
	// general status bit positions
	localparam int GS_FAULT = 7;
	localparam int GS_ALERT = 6;
	localparam int GS_PGOOD = 5;
	localparam int GS_READY = 4;
	// phase status: bit 7 = phase 6 down to bit 3 = phase 2
	localparam int PH_LO = 3;
	localparam int NUM_SRC = 8;
	// fractional bits of the temperature gain
	localparam int GAIN_FRAC = 8;

	// per-source conditions, bit order matches the mask registers
	typedef struct packed {
		logic vout;
		logic iout;
		logic input_st;
		logic temp;
		logic comm_logic;
		logic voltage_monitor;
		logic second_sense;
		logic output_power;
	} src_flags_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} reg_req_s;
endpackage
`default_nettype wire

// >>> sim/host_model.sv
// management-side host model: issues one register access at a time
// assumes requests are taken on the rising edge of clk_i
`default_nettype none
module host_model
	import mon_regs_pkg::*;
(
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	input wire logic rvalid_i,
	output var mon_regs_pkg::reg_req_s req_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial req_o = '0;
	// strobe held one edge, then an idle edge so no signal is driven twice in one step
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		req_o = {w, ~w, a, d};
		@(posedge clk_i);
		#1;
		q = (rvalid_i === 1'b1) ? rdata_i : 'x;
		req_o = '0;
		@(posedge clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// >>> sim/tb_alert_fault_mask_status_regs.sv
// self-checking bench for the alert/fault mask and status register bank
// assumes host_model as the only requester and a 250 MHz clock
`default_nettype none
module tb_alert_fault_mask_status_regs
	import mon_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0;
	logic rst_b_i = 0;
	logic pg = 0;
	logic rdy = 0;
	logic rvalid, alert, fault, ea, ef;
	src_flags_s asrc = '0;
	src_flags_s fsrc = '0;
	reg_req_s req;
	logic [5:0] ph = '0;
	logic [15:0] ts = '0;
	logic [15:0] rdata, temp, wlim, q, gain, ofs;
	logic [7:0] aso, fso, am, fm, s;
	logic [31:0] r, r2;
	logic [15:0] rv [7];
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int seed = 32'h0668e7c9;
	always #2 clk_i = ~clk_i;
	host_model host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
	alert_fault_mask_status_regs dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .alert_src_i(asrc),
		.fault_src_i(fsrc), .power_good_i(pg), .ready_i(rdy), .phase_en_i(ph), .thermal_sense_input_i(ts),
		.rdata_o(rdata), .rvalid_o(rvalid), .alert_o(alert), .fault_o(fault), .temperature_o(temp),
		.monitor_warn_limit_o(wlim), .alert_src_o(aso), .fault_src_o(fso));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] temp_f(input logic [15:0] v, input logic [15:0] g, input logic [15:0] o);
		logic [31:0] p;
		p = v * g;
		return p[23:8] - o;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host.acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		host.acc(1'b0, a, 16'h0000, q);
		chk(q, e);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// generous ceiling: the sequence needs about 1200 cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rv = '{RST_MON_WARN, RST_TS_GAIN, RST_TS_OFFSET, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		repeat (6) @(posedge clk_i);
		#1;
		rst_b_i = 1;
		@(posedge clk_i);
		#1;
		for (int i = 0; i < 7; i++) rd(OFS_MON_WARN + 8'(i), rv[i]);
		rd(8'h10, 16'h0000);
		// first 16 passes walk one source against one mask bit, the rest are random
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			r2 = $random(seed);
			s = 8'h01 << (i % 8);
			asrc = i < 16 ? s : r[7:0];
			fsrc = i < 16 ? s : r[15:8];
			am = i < 8 ? s : (i < 16 ? 8'h00 : r[23:16]);
			fm = i < 8 ? 8'h00 : (i < 16 ? s : r[31:24]);
			{pg, rdy, ph} = r2[7:0];
			ts = r2[31:16];
			gain = r2[23:8];
			ofs = r[15:0];
			ea = |(asrc & ~am);
			ef = |(fsrc & ~fm);
			wr(OFS_ALERT_MASK, {r2[15:8], am});
			wr(OFS_FAULT_MASK, {r2[15:8], fm});
			wr(OFS_TS_GAIN, gain);
			wr(OFS_TS_OFFSET, ofs);
			wr(OFS_GEN_STATUS, r[15:0]);
			wr(OFS_PHASE_STATUS, r[31:16]);
			wr(OFS_MON_WARN, r2[15:0]);
			rd(OFS_MON_WARN, r2[15:0]);
			rd(OFS_ALERT_MASK, {8'h00, am});
			rd(OFS_FAULT_MASK, {8'h00, fm});
			rd(OFS_TS_GAIN, gain);
			rd(OFS_TS_OFFSET, ofs);
			rd(OFS_GEN_STATUS, {8'h00, ef, ea, pg, rdy, 4'h0});
			rd(OFS_PHASE_STATUS, {8'h00, ph[5:1], 3'b000});
			chk({15'h0000, alert}, {15'h0000, ea});
			chk({15'h0000, fault}, {15'h0000, ef});
			chk({aso, fso}, {asrc, fsrc});
			chk(temp, temp_f(ts, gain, ofs));
			chk(wlim, r2[15:0]);
		end
		// reset in mid-run: every register must fall back to its default
		asrc = '0;
		fsrc = '0;
		{pg, rdy, ph} = 8'h00;
		@(posedge clk_i);
		#1;
		rst_b_i = 0;
		repeat (2) @(posedge clk_i);
		#1;
		rst_b_i = 1;
		@(posedge clk_i);
		#1;
		chk(wlim, RST_MON_WARN);
		chk({14'h0000, alert, fault}, 16'h0000);
		for (int i = 0; i < 7; i++) rd(OFS_MON_WARN + 8'(i), rv[i]);
		print_verdict();
	end
endmodule
`default_nettype wire
